// >>> logic/usc_defines.svh
// Purpose: Offsets, fields, reset values and counts
// Assumes: 32-bit APB, full byte addresses
// Notes:   Shared by package and modules
`ifndef USC_DEFINES_SVH
`define USC_DEFINES_SVH
`define USC_A_SBCR     32'h5000_1090
`define USC_A_SDMAM    32'h5000_1094
`define USC_A_SFE      32'h5000_1098
`define USC_A_SRT      32'h5000_109c
`define USC_A_LCR      32'h5000_10b0
`define USC_A_FCR      32'h5000_10b4
`define USC_A_MCR      32'h5000_10b8
`define USC_A_ISTS     32'h5000_10bc
`define USC_A_IMSK     32'h5000_10ac
`define USC_LCR_BRK    6
`define USC_MCR_LOOP   4
`define USC_MCR_SIR    6
`define USC_FCR_EN     0
`define USC_FCR_RFR    1
`define USC_FCR_XFR    2
`define USC_FCR_DMA    3
`define USC_FCR_TRG_LO 6
`define USC_FCR_TRG_HI 7
`define USC_EV_BRK     0
`define USC_EV_FRST    1
`define USC_EV_RXHIT   2
`define USC_EV_W       3
`define USC_RST_EV     3'h0
`define USC_FIFO_DEPTH 5'h10
`define USC_TRIG_ONE   5'h01
`define USC_TRIG_QTR   5'h04
`define USC_TRIG_HALF  5'h08
`define USC_TRIG_TWO   5'h0e
`define USC_SIR_PER    3'h7
`define USC_SIR_LOW    3'h2
`endif

// >>> logic/usc_pkg.sv
// Purpose: Types and decode helpers of the shadow control block
// Assumes: usc_defines.svh holds every address, bit field and level; register codes stay in usc_reg_e
// Notes:   usc_trig_level is shared by both modules; usc_decode is used by usc_shadow_ctrl only
`include "usc_defines.svh"
package usc_pkg;
  typedef enum logic [3:0] {
    USC_R_SBCR  = 4'h0,
    USC_R_SDMAM = 4'h1,
    USC_R_SFE   = 4'h2,
    USC_R_SRT   = 4'h3,
    USC_R_LCR   = 4'h4,
    USC_R_FCR   = 4'h5,
    USC_R_MCR   = 4'h6,
    USC_R_ISTS  = 4'h7,
    USC_R_IMSK  = 4'h8,
    USC_R_NONE  = 4'hf
  } usc_reg_e;

  typedef struct packed {
    logic [1:0] rx_trig;
    logic       dma_mode;
    logic       fifo_en;
  } usc_fcr_s;

  typedef struct packed {
    usc_fcr_s         fifo_control_register;
    logic             brk;
    logic             loop;
    logic             sir;
    logic [`USC_EV_W-1:0] sts;
    logic [`USC_EV_W-1:0] msk;
    logic             rx_hit;
    logic [2:0]       sir_cnt;
    logic             sin_q1;
    logic             sin_q2;
    logic             sout;
    logic             sir_out_n;
    logic             loop_rx;
    logic             txf_rst;
    logic             rxf_rst;
    logic             irq;
    logic             pready;
    logic             pslverr;
    logic [31:0]      prdata;
  } usc_state_s;

  typedef struct packed {
    logic rx_arm;
    logic tx_arm;
    logic rx_req_n;
    logic tx_req_n;
  } usc_dma_s;

  function automatic usc_reg_e usc_decode(input logic [31:0] a);
    case (a)
      `USC_A_SBCR:  usc_decode = USC_R_SBCR;
      `USC_A_SDMAM: usc_decode = USC_R_SDMAM;
      `USC_A_SFE:   usc_decode = USC_R_SFE;
      `USC_A_SRT:   usc_decode = USC_R_SRT;
      `USC_A_LCR:   usc_decode = USC_R_LCR;
      `USC_A_FCR:   usc_decode = USC_R_FCR;
      `USC_A_MCR:   usc_decode = USC_R_MCR;
      `USC_A_ISTS:  usc_decode = USC_R_ISTS;
      `USC_A_IMSK:  usc_decode = USC_R_IMSK;
      default:      usc_decode = USC_R_NONE;
    endcase
  endfunction

  // Codes 01 and 10 print alike; quarter and half are taken
  function automatic logic [4:0] usc_trig_level(input logic [1:0] code);
    case (code)
      2'h0:    usc_trig_level = `USC_TRIG_ONE;
      2'h1:    usc_trig_level = `USC_TRIG_QTR;
      2'h2:    usc_trig_level = `USC_TRIG_HALF;
      default: usc_trig_level = `USC_TRIG_TWO;
    endcase
  endfunction
endpackage

// >>> logic/usc_dma_req.sv
// Purpose: Transmit and receive DMA request generation
// Assumes: Levels come from the FIFOs on the same clock
// Notes:   Requests are active low and registered
`timescale 1ns/1ps
module usc_dma_req import usc_pkg::*; (
  // Clock and reset
  input  wire logic     clk,
  input  wire logic     srst,
  // Settings
  input  wire usc_fcr_s fifo_control_register,
  // FIFO levels
  input  wire logic [4:0] rx_level,
  input  wire logic [4:0] tx_level,
  // Requests
  output logic          dma_rx_req_n,
  output logic          dma_tx_req_n
);
  usc_dma_s s, n;
  logic     m1;
  logic     rx_at;

  always_comb begin
    n     = s;
    m1    = fifo_control_register.dma_mode && fifo_control_register.fifo_en;
    rx_at = rx_level >= usc_trig_level(fifo_control_register.rx_trig);
    if (!m1) begin
      n.rx_arm = rx_level != 5'h0;
      n.tx_arm = tx_level == 5'h0;
    end else begin
      // Mode 1 raises rx on the trigger, holds until drained; tx raises on empty, holds until full
      if (rx_at) n.rx_arm = 1'b1;
      else if (rx_level == 5'h0) n.rx_arm = 1'b0;
      if (tx_level == 5'h0) n.tx_arm = 1'b1;
      else if (tx_level == `USC_FIFO_DEPTH) n.tx_arm = 1'b0;
    end
    n.rx_req_n = !n.rx_arm;
    n.tx_req_n = !n.tx_arm;
  end

  always_ff @(posedge clk) begin
    if (srst) s <= '{rx_arm: 1'b0, tx_arm: 1'b0, rx_req_n: 1'b1, tx_req_n: 1'b1};
    else s <= n;
  end

  assign dma_rx_req_n = s.rx_req_n;
  assign dma_tx_req_n = s.tx_req_n;

  a_dma_rx_trig: assert property (@(posedge clk) disable iff (srst)
    fifo_control_register.dma_mode && fifo_control_register.fifo_en && rx_level >= usc_trig_level(fifo_control_register.rx_trig)
    |=> !dma_rx_req_n) else $error("rx request missing at trigger");
  a_dma_rx_m0: assert property (@(posedge clk) disable iff (srst)
    !fifo_control_register.dma_mode && rx_level == 5'h0 |=> dma_rx_req_n)
    else $error("mode 0 rx request while empty");
endmodule // usc_dma_req

// >>> logic/usc_shadow_ctrl.sv
// Purpose: Shadow and base control fields of the serial port, APB slave
// Assumes: Transmitter, receiver and FIFOs sit outside on clk
// Notes:   Each shadow shares one flop with its control field
`timescale 1ns/1ps
module usc_shadow_ctrl import usc_pkg::*; (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Transmitter side
  input  wire logic        tx_serial,
  input  wire logic        tx_sir_n,
  // Receive pin and receiver input
  input  wire logic        sin,
  output logic             rx_serial,
  // Serial pins
  output logic             sout,
  output logic             sir_out_n,
  // FIFO controller
  input  wire logic [4:0]  rx_level,
  input  wire logic [4:0]  tx_level,
  output logic             tx_fifo_rst,
  output logic             rx_fifo_rst,
  output logic             fifo_en,
  output logic [4:0]       rx_trig_level,
  // DMA requests
  output logic             dma_rx_req_n,
  output logic             dma_tx_req_n,
  // Interrupt
  output logic             irq
);
  usc_state_s            s, n;
  usc_reg_e              rsel;
  logic                  setup;
  logic                  wr;
  logic                  hit;
  logic [`USC_EV_W-1:0]  ev;
  logic [31:0]           rd;
  logic [4:0]            trig_r;

  ////////////////////////////////////////////////////////////////////
  // Register decode and read view
  always_comb begin
    rsel  = usc_decode(paddr);
    setup = psel && !penable;
    wr    = psel && penable && s.pready && pwrite;
    rd    = 32'h0;
    case (rsel)
      USC_R_SBCR:  rd[0]   = s.brk;
      USC_R_SDMAM: rd[0]   = s.fifo_control_register.dma_mode;
      USC_R_SFE:   rd[0]   = s.fifo_control_register.fifo_en;
      USC_R_SRT:   rd[1:0] = s.fifo_control_register.rx_trig;
      USC_R_LCR:   rd[`USC_LCR_BRK] = s.brk;
      USC_R_FCR: begin
        rd[`USC_FCR_EN]  = s.fifo_control_register.fifo_en;
        rd[`USC_FCR_DMA] = s.fifo_control_register.dma_mode;
        rd[`USC_FCR_TRG_HI:`USC_FCR_TRG_LO] = s.fifo_control_register.rx_trig;
      end
      USC_R_MCR: begin
        rd[`USC_MCR_LOOP] = s.loop;
        rd[`USC_MCR_SIR]  = s.sir;
      end
      USC_R_ISTS:  rd[`USC_EV_W-1:0] = s.sts;
      USC_R_IMSK:  rd[`USC_EV_W-1:0] = s.msk;
      default:     rd = 32'h0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    n         = s;
    ev        = `USC_RST_EV;
    // Pin crosses in through two flops
    n.sin_q1  = sin;
    n.sin_q2  = s.sin_q1;
    // Read data is latched in setup so it stands through access
    n.pready  = setup;
    n.pslverr = setup && rsel == USC_R_NONE;
    n.prdata  = setup && !pwrite ? rd : 32'h0;
    n.txf_rst = 1'b0;
    n.rxf_rst = 1'b0;
    if (wr) begin
      case (rsel)
        USC_R_SBCR:  n.brk = pwdata[0];
        USC_R_SDMAM: n.fifo_control_register.dma_mode = pwdata[0];
        USC_R_SFE:   n.fifo_control_register.fifo_en  = pwdata[0];
        USC_R_SRT:   n.fifo_control_register.rx_trig  = pwdata[1:0];
        USC_R_LCR:   n.brk = pwdata[`USC_LCR_BRK];
        USC_R_FCR: begin
          n.fifo_control_register.fifo_en  = pwdata[`USC_FCR_EN];
          n.fifo_control_register.dma_mode = pwdata[`USC_FCR_DMA];
          n.fifo_control_register.rx_trig  = pwdata[`USC_FCR_TRG_HI:`USC_FCR_TRG_LO];
          n.txf_rst      = pwdata[`USC_FCR_XFR];
          n.rxf_rst      = pwdata[`USC_FCR_RFR];
        end
        USC_R_MCR: begin
          n.loop = pwdata[`USC_MCR_LOOP];
          n.sir  = pwdata[`USC_MCR_SIR];
        end
        USC_R_IMSK:  n.msk = pwdata[`USC_EV_W-1:0];
        default:     n.msk = s.msk;
      endcase
    end
    // Disabling the FIFOs flushes both controllers
    if (s.fifo_control_register.fifo_en && !n.fifo_control_register.fifo_en) begin
      n.txf_rst = 1'b1;
      n.rxf_rst = 1'b1;
    end
    // Without FIFOs a single held character counts as reached
    hit = s.fifo_control_register.fifo_en ? rx_level >= usc_trig_level(s.fifo_control_register.rx_trig)
                        : rx_level != 5'h0;
    n.rx_hit = hit;
    ev[`USC_EV_BRK]   = n.brk && !s.brk;
    ev[`USC_EV_FRST]  = s.fifo_control_register.fifo_en && !n.fifo_control_register.fifo_en;
    ev[`USC_EV_RXHIT] = hit && !s.rx_hit;
    // Write-one-to-clear; a new event in the same cycle wins
    if (wr && rsel == USC_R_ISTS) n.sts = s.sts & ~pwdata[`USC_EV_W-1:0];
    n.sts = n.sts | ev;
    n.irq = |(n.sts & n.msk);
    // Infrared break waveform counter
    if (s.brk && s.sir && !s.loop) n.sir_cnt = s.sir_cnt == `USC_SIR_PER ? 3'h0 : 3'(s.sir_cnt + 3'h1);
    else n.sir_cnt = 3'h0;
    // Loopback keeps the pins idle and feeds the receiver
    if (s.loop) begin
      n.sout      = 1'b1;
      n.sir_out_n = 1'b1;
      n.loop_rx   = s.brk ? 1'b0 : tx_serial;
    end else begin
      n.sout      = s.brk ? 1'b0 : tx_serial;
      n.sir_out_n = s.brk && s.sir ? !(s.sir_cnt < `USC_SIR_LOW) : tx_sir_n;
      n.loop_rx   = s.sin_q2;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk) begin
    if (srst) begin
      s         <= '0;
      s.sin_q1  <= 1'b1;
      s.sin_q2  <= 1'b1;
      s.sout    <= 1'b1;
      s.sir_out_n <= 1'b1;
      s.loop_rx <= 1'b1;
    end else begin
      s <= n;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) trig_r <= `USC_TRIG_ONE;
    else trig_r <= usc_trig_level(n.fifo_control_register.rx_trig);
  end

  assign prdata        = s.prdata;
  assign pready        = s.pready;
  assign pslverr       = s.pslverr;
  assign sout          = s.sout;
  assign sir_out_n     = s.sir_out_n;
  assign rx_serial     = s.loop_rx;
  assign tx_fifo_rst   = s.txf_rst;
  assign rx_fifo_rst   = s.rxf_rst;
  assign fifo_en       = s.fifo_control_register.fifo_en;
  assign rx_trig_level = trig_r;
  assign irq           = s.irq;

  ////////////////////////////////////////////////////////////////////
  // DMA request generation
  usc_dma_req u_dma (
    .clk          (clk),
    .srst         (srst),
    .fifo_control_register          (s.fifo_control_register),
    .rx_level     (rx_level),
    .tx_level     (tx_level),
    .dma_rx_req_n (dma_rx_req_n),
    .dma_tx_req_n (dma_tx_req_n)
  );

  ////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_apb_wr(usc_reg_e r);
    psel && penable && pready && pwrite && usc_decode(paddr) == r;
  endsequence

  sequence s_sir_brk;
    s.brk && s.sir && !s.loop;
  endsequence

  a_break_shadow: assert property (@(posedge clk) disable iff (srst)
    s_apb_wr(USC_R_SBCR) |=> s.brk == $past(pwdata[0]) && !$past(s.loop) == !s.loop)
    else $error("break shadow did not store");
  a_break_lcr: assert property (@(posedge clk) disable iff (srst)
    s_apb_wr(USC_R_LCR) ##[1:2] (psel && !penable && usc_decode(paddr) == USC_R_SBCR && !pwrite)
    |=> prdata[0] == s.brk) else $error("break views disagree");
  a_break_low: assert property (@(posedge clk) disable iff (srst)
    s.brk && !s.loop |=> !sout) else $error("break not driving line low");
  a_sir_pulse: assert property (@(posedge clk) disable iff (srst)
    s_sir_brk ##0 (s.sir_cnt == 3'h0) |=> !sir_out_n ##1 (!sir_out_n || !$past(s.brk && s.sir && !s.loop)))
    else $error("infrared break pulse missing");
  a_loop_break: assert property (@(posedge clk) disable iff (srst)
    s.loop && s.brk |=> !rx_serial && sout) else $error("loopback break not internal");
  a_dma_shadow: assert property (@(posedge clk) disable iff (srst)
    s_apb_wr(USC_R_SDMAM) |=> s.fifo_control_register.dma_mode == $past(pwdata[0]))
    else $error("dma mode shadow not stored");
  a_fifo_enable: assert property (@(posedge clk) disable iff (srst)
    s_apb_wr(USC_R_SFE) |=> fifo_en == $past(pwdata[0])) else $error("fifo enable wrong");
  a_fifo_flush: assert property (@(posedge clk) disable iff (srst)
    $fell(s.fifo_control_register.fifo_en) |-> tx_fifo_rst && rx_fifo_rst ##1 !tx_fifo_rst)
    else $error("fifo flush not pulsed");
  a_trig_shadow: assert property (@(posedge clk) disable iff (srst)
    s_apb_wr(USC_R_SRT) |=> ##1 rx_trig_level == usc_trig_level($past(pwdata[1:0], 2)))
    else $error("trigger level not applied");
  a_trig_codes: assert property (@(posedge clk) disable iff (srst)
    s.fifo_control_register.rx_trig == 2'h3 |=> rx_trig_level == `USC_TRIG_TWO || $changed(s.fifo_control_register.rx_trig))
    else $error("trigger code 11 decode wrong");
  a_upper_zero: assert property (@(posedge clk) disable iff (srst)
    psel && !penable && !pwrite && rsel inside {USC_R_SBCR, USC_R_SDMAM, USC_R_SFE}
    |=> prdata[31:1] == 31'h0 && pready) else $error("reserved bits not zero");
  a_sts_set_wins: assert property (@(posedge clk) disable iff (srst)
    ev[`USC_EV_BRK] |=> s.sts[`USC_EV_BRK]) else $error("event lost on clear");
  a_irq_level: assert property (@(posedge clk) disable iff (srst)
    |(s.sts & s.msk) |-> irq) else $error("irq low with pending event");
endmodule // usc_shadow_ctrl

// >>> sim/usc_remote_dev.sv
// Purpose: Remote serial device on the far end of the line
// Assumes: Shares the block clock; samples one bit per cycle
// Notes:   Keeps its transmit line at mark; measures spacing runs
`timescale 1ns/1ps
module usc_remote_dev (
  // Clock and control
  input  wire logic clk,
  input  wire logic clr,
  // Line
  input  wire logic line_in,
  output logic      line_out,
  // Observation
  output int        max_low
);
  int low_run;
  ////////////////////////////////////////////////////////////////////////
  // Never floats its line: an idle far end holds mark
  initial line_out = 1'b1;
  initial low_run = 0;
  initial max_low = 0;
  always @(posedge clk) begin
    low_run <= (line_in === 1'b0) ? low_run + 1 : 0;
    if (clr) max_low <= 0;
    else if (low_run > max_low) max_low <= low_run;
  end
endmodule // usc_remote_dev

// >>> sim/testbench.sv
// Purpose: Self-checking bench of the shadow control block
// Assumes: APB master on clk, register model kept in integers
// Notes:   Far end sits on sout/sin; levels driven by the bench
`timescale 1ns/1ps
`include "usc_defines.svh"
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin error_cnt++; \
  $display("FAIL %s exp %h got %h", nm, (ex), (got)); end end
module testbench;
  logic        clk, srst, psel, penable, pwrite, tx_serial, tx_sir_n, sin, clr, err;
  logic [31:0] paddr, pwdata, prdata, q, lfsr_r;
  logic        pready, pslverr, rx_serial, sout, sir_out_n, tx_fifo_rst, rx_fifo_rst;
  logic        fifo_en, dma_rx_req_n, dma_tx_req_n, irq;
  logic [4:0]  rx_level, tx_level, rx_trig_level;
  int          error_cnt, checked, rst_seen, exp_rst, max_low, n;
  int          sh[4];
  int          msk[4] = '{1, 1, 1, 3};
  int          lvl[4] = '{1, 4, 8, 14};
  int          dlv[4] = '{7, 8, 3, 0};
  logic        dex[4] = '{1'b1, 1'b0, 1'b0, 1'b1};
  ////////////////////////////////////////////////////////////////////////
  usc_shadow_ctrl uut (.clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_serial(tx_serial), .tx_sir_n(tx_sir_n), .sin(sin), .rx_serial(rx_serial), .sout(sout),
    .sir_out_n(sir_out_n), .rx_level(rx_level), .tx_level(tx_level), .tx_fifo_rst(tx_fifo_rst),
    .rx_fifo_rst(rx_fifo_rst), .fifo_en(fifo_en), .rx_trig_level(rx_trig_level),
    .dma_rx_req_n(dma_rx_req_n), .dma_tx_req_n(dma_tx_req_n), .irq(irq));
  usc_remote_dev peer (.clk(clk), .clr(clr), .line_in(sout), .line_out(sin), .max_low(max_low));
  always #12.5 clk = ~clk;
  always @(posedge clk) if (tx_fifo_rst === 1'b1 && rx_fifo_rst === 1'b1) rst_seen++;
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] addr(input int i);
    return `USC_A_SBCR + 32'(4 * i);
  endfunction
  task automatic results();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Holds the request until pready is seen at an edge, then idles a cycle
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int k = 0;
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin @(posedge clk); k++; end while (pready !== 1'b1 && k < 16);
    q = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    if (pready !== 1'b1) begin error_cnt++; $display("FAIL apb timeout"); results(); end
    @(posedge clk);
  endtask
  task automatic wsh(input int i, input logic [31:0] d);
    if (i == 2 && sh[2] == 1 && d[0] == 1'b0) exp_rst++;
    apb(1'b1, addr(i), d);
    sh[i] = d & msk[i];
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 0; srst = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; clr = 0;
    tx_serial = 1; tx_sir_n = 1; rx_level = 0; tx_level = 0; lfsr_r = 32'h361f1d91;
    error_cnt = 0; checked = 0; rst_seen = 0; exp_rst = 0; sh = '{0, 0, 0, 0};
    tick(10);
    srst <= 1'b0;
    tick(1);
    `CHK("en_rst", 1'b0, fifo_en)
    `CHK("trig_rst", lvl[0], rx_trig_level)
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, addr(i), 32'h0);
      `CHK("shadow_rst", 32'h0, q)
    end
    $display("test reset done");
    // Random words, upper bits included, must land only in their field
    for (int k = 0; k < 16; k++) begin
      lfsr_r = lfsr(lfsr_r);
      wsh(k % 4, lfsr_r);
      tick(2);
      apb(1'b0, addr(k % 4), 32'h0);
      `CHK("shadow", sh[k % 4], q)
      apb(1'b0, `USC_A_LCR, 32'h0);
      `CHK("line_img", sh[0] << 6, q & 32'h40)
      apb(1'b0, `USC_A_FCR, 32'h0);
      `CHK("fifo_img", (sh[3] << 6) | (sh[1] << 3) | sh[2], q & 32'hc9)
      `CHK("fifo_en", sh[2][0], fifo_en)
      `CHK("fifo_rst", exp_rst, rst_seen)
    end
    wsh(2, 32'h1);
    wsh(2, 32'h0);
    tick(2);
    `CHK("fifo_rst_fall", exp_rst, rst_seen)
    $display("test shadows done");
    for (int c = 0; c < 4; c++) begin
      wsh(3, c);
      tick(2);
      `CHK("trig_lvl", lvl[c], rx_trig_level)
      apb(1'b0, `USC_A_FCR, 32'h0);
      `CHK("trig_img", c, q[7:6])
    end
    $display("test trigger done");
    wsh(2, 32'h1);
    wsh(1, 32'h1);
    wsh(3, 32'h2);
    for (int k = 0; k < 4; k++) begin
      rx_level <= 5'(dlv[k]);
      tick(3);
      `CHK("dma_rx_m1", dex[k], dma_rx_req_n)
    end
    tx_level <= 5'h10;
    tick(3);
    `CHK("dma_tx_full", 1'b1, dma_tx_req_n)
    tx_level <= 5'h05;
    tick(3);
    `CHK("dma_tx_hold", 1'b1, dma_tx_req_n)
    wsh(1, 32'h0);
    tick(3);
    `CHK("dma_tx_m0_busy", 1'b1, dma_tx_req_n)
    rx_level <= 5'h01;
    tx_level <= 5'h00;
    tick(3);
    `CHK("dma_rx_m0", 1'b0, dma_rx_req_n)
    `CHK("dma_tx_m0", 1'b0, dma_tx_req_n)
    $display("test dma done");
    wsh(0, 32'h0);
    apb(1'b1, `USC_A_MCR, 32'h0);
    apb(1'b1, `USC_A_IMSK, 32'h1);
    apb(1'b1, `USC_A_ISTS, 32'h7);
    clr <= 1'b1;
    tick(1);
    clr <= 1'b0;
    wsh(0, 32'h1);
    tick(20);
    `CHK("sout_brk", 1'b0, sout)
    `CHK("brk_len", 1'b1, max_low >= 16)
    `CHK("irq_set", 1'b1, irq)
    apb(1'b1, `USC_A_ISTS, 32'h1);
    tick(2);
    `CHK("irq_clr", 1'b0, irq)
    apb(1'b1, `USC_A_MCR, 32'h10);
    tick(3);
    `CHK("sout_loop", 1'b1, sout)
    `CHK("rx_loop", 1'b0, rx_serial)
    apb(1'b1, `USC_A_MCR, 32'h40);
    tick(2);
    n = 0;
    repeat (16) begin @(posedge clk); if (sir_out_n === 1'b0) n++; end
    `CHK("sir_lows", 16 / (`USC_SIR_PER + 1) * `USC_SIR_LOW, n)
    apb(1'b1, `USC_A_MCR, 32'h0);
    apb(1'b1, `USC_A_IMSK, 32'h0);
    wsh(0, 32'h0);
    for (int k = 0; k < 8; k++) begin
      lfsr_r = lfsr(lfsr_r);
      tx_serial <= lfsr_r[0];
      tx_sir_n  <= lfsr_r[1];
      tick(2);
      `CHK("sout_free", lfsr_r[0], sout)
      `CHK("sir_free", lfsr_r[1], sir_out_n)
    end
    tx_serial <= 1'b1;
    tx_sir_n  <= 1'b1;
    wsh(0, 32'h1);
    tick(3);
    `CHK("irq_masked", 1'b0, irq)
    wsh(0, 32'h0);
    $display("test break done");
    apb(1'b0, 32'h5000_1000, 32'h0);
    `CHK("unmapped_err", 1'b1, err)
    `CHK("unmapped_rd", 32'h0, q)
    $display("test unmapped done");
    apb(1'b1, `USC_A_LCR, 32'h40);
    apb(1'b0, addr(0), 32'h0);
    `CHK("lcr_to_shadow", 32'h1, q)
    apb(1'b1, `USC_A_LCR, 32'h0);
    apb(1'b1, `USC_A_FCR, 32'hc7);
    exp_rst++;
    tick(2);
    `CHK("fifo_img_rst", exp_rst, rst_seen)
    apb(1'b0, addr(3), 32'h0);
    `CHK("trig_via_img", 32'h3, q)
    $display("test images done");
    results();
  end
endmodule // testbench
